// ---- hdl/psf_pkg.sv ----
// constants and types of the permanent-failure safety block
package psf_pkg;
  typedef logic [7:0]  psf_addr_t;
  typedef logic [31:0] psf_word_t;
  typedef logic [15:0] psf_half_t;

  // time base
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NS_PER_S      = 1000000000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES   =
    TICK_PERIOD_S * NS_PER_S / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 28;

  // fault indices
  localparam int NFAULT   = 4;
  localparam int F_CHG_OC = 0;
  localparam int F_DSG_OC = 1;
  localparam int F_CHG_OT = 2;
  localparam int F_DSG_OT = 3;

  // confirmation time fields, whole seconds
  localparam int TIME_W = 8;
  localparam logic [TIME_W-1:0] TIME_ZERO = 8'h00;
  localparam logic [TIME_W-1:0] TIME_ONE  = 8'h01;

  // register byte addresses
  localparam psf_addr_t A_CTRL     = 8'h00;
  localparam psf_addr_t A_CHG_OC   = 8'h04;
  localparam psf_addr_t A_DSG_OC   = 8'h08;
  localparam psf_addr_t A_CHG_OT   = 8'h0c;
  localparam psf_addr_t A_DSG_OT   = 8'h10;
  localparam psf_addr_t A_TIMES    = 8'h14;
  localparam psf_addr_t A_PF_CFG   = 8'h18;
  localparam psf_addr_t A_CHG_CUR  = 8'h1c;
  localparam psf_addr_t A_CHG_VOLT = 8'h20;
  localparam psf_addr_t A_ALERT    = 8'h24;
  localparam psf_addr_t A_LATCHED  = 8'h28;
  localparam psf_addr_t A_FUSE     = 8'h2c;
  localparam psf_addr_t A_BSTAT    = 8'h30;
  localparam psf_addr_t A_SNAP0    = 8'h34;
  localparam psf_addr_t A_SNAP1    = 8'h38;

  // field positions
  localparam int CTRL_FET_LSB   = 0;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int BST_CHG_ALARM  = 0;
  localparam int BST_DSG_ALARM  = 1;
  localparam int BST_DSG        = 2;
  localparam int BST_SNAP_VALID = 3;

  // reset values and fixed words
  localparam logic [2:0]        RST_FET     = 3'h0;
  localparam psf_half_t         RST_LIMIT   = 16'h7fff;
  localparam psf_half_t         RST_REQ     = 16'h0000;
  localparam logic [NFAULT-1:0] RST_CFG     = 4'h0;
  localparam psf_word_t         RST_TIMES   = 32'h0000_0000;
  localparam psf_half_t         FUSE_MAGIC  = 16'h3672;
  localparam psf_half_t         HALF_ZERO   = 16'h0000;
  localparam psf_word_t         WORD_ZERO   = 32'h0000_0000;
endpackage

// ---- hdl/psf_fault_timer.sv ----
// alert flag, confirmation timer and latch for one fault
`timescale 1ns/1ps
module psf_fault_timer (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      tick,
  input  wire logic                      cond,
  input  wire logic [psf_pkg::TIME_W-1:0] confirm_time,
  input  wire logic                      clear,
  output logic                           alert,
  output logic                           latched
);
  import psf_pkg::*;

  logic [TIME_W-1:0] count_reg;
  logic              enabled;
  logic              expire;

  // zero time switches the whole function off
  assign enabled = (confirm_time != TIME_ZERO);
  assign expire  = enabled && alert && cond && tick &&
                   ((TIME_W)'(count_reg + TIME_ONE) >= confirm_time);

  // alert follows the condition, so a vanished fault drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert <= 1'b0;
    end else if (clear || !enabled || !cond) begin
      alert <= 1'b0;
    end else begin
      alert <= 1'b1;
    end
  end

  // whole seconds counted from the tick; restarts whenever alert drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= TIME_ZERO;
    end else if (!alert || !cond || !enabled) begin
      count_reg <= TIME_ZERO;
    end else if (tick && count_reg != {TIME_W{1'b1}}) begin
      count_reg <= (TIME_W)'(count_reg + TIME_ONE);
    end
  end

  // expiry wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched <= 1'b0;
    end else if (expire) begin
      latched <= 1'b1;
    end else if (clear) begin
      latched <= 1'b0;
    end
  end
endmodule // psf_fault_timer

// ---- hdl/psf_safety_top.sv ----
// permanent-failure safety block: limits, timers, shutdown and apb
`timescale 1ns/1ps
module psf_safety_top #(
  parameter int unsigned TICK_CYCLES = psf_pkg::TICK_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire psf_pkg::psf_addr_t   paddr,
  input  wire psf_pkg::psf_word_t   pwdata,
  output psf_pkg::psf_word_t        prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire psf_pkg::psf_half_t   meas_current,
  input  wire psf_pkg::psf_half_t   meas_temp,
  input  wire logic                 discharging,
  input  wire psf_pkg::psf_half_t   sbs_voltage,
  input  wire psf_pkg::psf_half_t   afe_status,
  output logic                      chg_fet_on,
  output logic                      dsg_fet_on,
  output logic                      pchg_fet_on,
  output logic                      terminate_charge_alarm,
  output logic                      terminate_discharge_alarm,
  output psf_pkg::psf_half_t        charge_current_req,
  output psf_pkg::psf_half_t        charge_voltage_req,
  output logic                      safety_out,
  output logic                      fault_latched
);
  import psf_pkg::*;

  logic [2:0]           fet_req_reg;
  psf_half_t            chg_oc_limit_reg;
  psf_half_t            dsg_oc_limit_reg;
  psf_half_t            charge_temp_limit;
  psf_half_t            discharge_temp_limit;
  psf_word_t            times_reg;
  logic [NFAULT-1:0]    fuse_cfg_reg;
  psf_half_t            chg_cur_reg;
  psf_half_t            chg_volt_reg;
  psf_half_t            fuse_flag_reg;
  logic [NFAULT-1:0]    fault_alert_word;
  logic [NFAULT-1:0]    fault_latched_word;
  logic [NFAULT-1:0]    latched_q;
  logic [NFAULT-1:0]    cond;
  logic [TICK_W-1:0]    tick_cnt_reg;
  logic                 tick;
  logic                 clear_reg;
  logic                 pf_any;
  logic                 pf_q;
  logic                 snap_valid_reg;
  psf_word_t            snap0_reg;
  psf_word_t            snap1_reg;
  psf_word_t            rd_mux;
  logic                 addr_ok;
  logic                 cfg_addr;
  logic                 setup;
  logic                 commit;
  logic                 cfg_we;
  logic signed [16:0]   cur_s;
  logic                 fuse_hit;

  assign pf_any = |fault_latched_word;
  assign setup  = psel && !penable;
  assign commit = psel && penable && pready && pwrite && !pslverr;
  // flash lock checked at commit too, in case a fault latches mid-access
  assign cfg_we = commit && !pf_any;

  // one-second tick; parameter lets a simulation shorten it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= (TICK_W)'(tick_cnt_reg + 1'b1);
    end
  end
  assign tick = (tick_cnt_reg == (TICK_W)'(TICK_CYCLES - 1));

  // fault conditions on signed current and unsigned temperature
  assign cur_s = $signed({meas_current[15], meas_current});
  assign cond[F_CHG_OC] = cur_s >= $signed({1'b0, chg_oc_limit_reg});
  assign cond[F_DSG_OC] = cur_s <= -$signed({1'b0, dsg_oc_limit_reg});
  assign cond[F_CHG_OT] = !discharging &&
                          (meas_temp >= charge_temp_limit);
  assign cond[F_DSG_OT] = discharging &&
                          (meas_temp >= discharge_temp_limit);

  // one timer per fault, each with its own alert and latch bit
  for (genvar i = 0; i < NFAULT; i++) begin : g_fault
    psf_fault_timer u_timer (
      .pclk         (pclk),
      .presetn      (presetn),
      .tick         (tick),
      .cond         (cond[i]),
      .confirm_time (times_reg[i*TIME_W +: TIME_W]),
      .clear        (clear_reg),
      .alert        (fault_alert_word[i]),
      .latched      (fault_latched_word[i])
    );
  end

  // apb ready: one wait-free access phase after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup && !pready;
    end
  end

  // unmapped address or locked configuration answers with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && (!addr_ok || (pwrite && cfg_addr && pf_any));
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= WORD_ZERO;
    end else if (setup && !pwrite && addr_ok) begin
      prdata <= rd_mux;
    end else begin
      prdata <= WORD_ZERO;
    end
  end

  // address decode and read mux
  always_comb begin
    rd_mux   = WORD_ZERO;
    addr_ok  = 1'b1;
    // flash words sit in one contiguous range; holes fail addr_ok anyway
    cfg_addr = (paddr >= A_CHG_OC) && (paddr <= A_PF_CFG);
    unique case (paddr)
      A_CTRL:     rd_mux = {29'h0, fet_req_reg};
      A_CHG_OC:   rd_mux = {16'h0, chg_oc_limit_reg};
      A_DSG_OC:   rd_mux = {16'h0, dsg_oc_limit_reg};
      A_CHG_OT:   rd_mux = {16'h0, charge_temp_limit};
      A_DSG_OT:   rd_mux = {16'h0, discharge_temp_limit};
      A_TIMES:    rd_mux = times_reg;
      A_PF_CFG:   rd_mux = {28'h0, fuse_cfg_reg};
      A_CHG_CUR:  rd_mux = {16'h0, chg_cur_reg};
      A_CHG_VOLT: rd_mux = {16'h0, chg_volt_reg};
      A_ALERT:    rd_mux = {28'h0, fault_alert_word};
      A_LATCHED:  rd_mux = {28'h0, fault_latched_word};
      A_FUSE:     rd_mux = {16'h0, fuse_flag_reg};
      A_BSTAT:    rd_mux = {28'h0, snap_valid_reg, discharging,
                            terminate_discharge_alarm,
                            terminate_charge_alarm};
      A_SNAP0:    rd_mux = snap0_reg;
      A_SNAP1:    rd_mux = snap1_reg;
      default:    addr_ok = 1'b0;
    endcase
  end

  // switch requests and clear command; clear stays usable under failure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fet_req_reg <= RST_FET;
      clear_reg   <= 1'b0;
    end else begin
      clear_reg <= commit && paddr == A_CTRL &&
                   pwdata[CTRL_CLEAR_BIT];
      if (commit && paddr == A_CTRL) begin
        fet_req_reg <= pwdata[CTRL_FET_LSB +: 3];
      end
    end
  end

  // configuration words, frozen while a failure is latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_oc_limit_reg     <= RST_LIMIT;
      dsg_oc_limit_reg     <= RST_LIMIT;
      charge_temp_limit    <= RST_LIMIT;
      discharge_temp_limit <= RST_LIMIT;
      times_reg            <= RST_TIMES;
      fuse_cfg_reg         <= RST_CFG;
    end else if (cfg_we) begin
      unique case (paddr)
        A_CHG_OC: chg_oc_limit_reg     <= pwdata[15:0];
        A_DSG_OC: dsg_oc_limit_reg     <= pwdata[15:0];
        A_CHG_OT: charge_temp_limit    <= pwdata[15:0];
        A_DSG_OT: discharge_temp_limit <= pwdata[15:0];
        A_TIMES:  times_reg            <= pwdata;
        A_PF_CFG: fuse_cfg_reg         <= pwdata[NFAULT-1:0];
        default:  ;
      endcase
    end
  end

  // charge requests are host values, not flash, so writes pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_cur_reg  <= RST_REQ;
      chg_volt_reg <= RST_REQ;
    end else if (commit) begin
      if (paddr == A_CHG_CUR) begin
        chg_cur_reg <= pwdata[15:0];
      end
      if (paddr == A_CHG_VOLT) begin
        chg_volt_reg <= pwdata[15:0];
      end
    end
  end

  // shutdown outputs; a latched failure overrides every request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_fet_on                <= 1'b0;
      dsg_fet_on                <= 1'b0;
      pchg_fet_on               <= 1'b0;
      terminate_charge_alarm    <= 1'b0;
      terminate_discharge_alarm <= 1'b0;
      charge_current_req        <= HALF_ZERO;
      charge_voltage_req        <= HALF_ZERO;
      fault_latched             <= 1'b0;
    end else begin
      chg_fet_on  <= fet_req_reg[0] && !pf_any;
      dsg_fet_on  <= fet_req_reg[1] && !pf_any;
      pchg_fet_on <= fet_req_reg[2] && !pf_any;
      terminate_charge_alarm    <= pf_any;
      terminate_discharge_alarm <= pf_any;
      charge_current_req <= pf_any ? HALF_ZERO : chg_cur_reg;
      charge_voltage_req <= pf_any ? HALF_ZERO : chg_volt_reg;
      fault_latched      <= pf_any;
    end
  end

  // edge of each latch, used for fuse and snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_q <= '0;
      pf_q      <= 1'b0;
    end else begin
      latched_q <= fault_latched_word;
      pf_q      <= pf_any;
    end
  end

  // fuse: newly latched fault with its fuse enable; set beats clear
  assign fuse_hit = |(fault_latched_word & ~latched_q & fuse_cfg_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_flag_reg <= HALF_ZERO;
      safety_out    <= 1'b0;
    end else if (fuse_hit) begin
      fuse_flag_reg <= FUSE_MAGIC;
      safety_out    <= 1'b1;
    end else if (clear_reg) begin
      fuse_flag_reg <= HALF_ZERO;
      safety_out    <= 1'b0;
    end
  end

  // failure record: snapshot kept across a clear for later analysis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_valid_reg <= 1'b0;
      snap0_reg      <= WORD_ZERO;
      snap1_reg      <= WORD_ZERO;
    end else if (pf_any && !pf_q) begin
      snap_valid_reg <= 1'b1;
      snap0_reg      <= {sbs_voltage, meas_current};
      snap1_reg      <= {afe_status, meas_temp};
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fet_open_pf: assert property (pf_any |=> !chg_fet_on && !dsg_fet_on
    && !pchg_fet_on) else $error("switch on under failure");
  a_alarm_bits: assert property (pf_any |=> terminate_charge_alarm &&
    terminate_discharge_alarm) else $error("alarm bits missing");
  a_req_zero: assert property (pf_any |=> charge_current_req == HALF_ZERO
    && charge_voltage_req == HALF_ZERO) else $error("req not zero");
  a_flash_locked: assert property (pf_any && $past(pf_any) |=>
    $stable(times_reg) && $stable(fuse_cfg_reg))
    else $error("config written under failure");
  a_fuse_fire: assert property (fuse_hit |=> fuse_flag_reg == FUSE_MAGIC
    && safety_out) else $error("fuse not fired");
  a_snap_take: assert property ($rose(pf_any) |=> snap_valid_reg)
    else $error("snapshot missing");
  a_chg_oc_alert: assert property (cond[F_CHG_OC] && !clear_reg &&
    times_reg[F_CHG_OC*TIME_W +: TIME_W] != TIME_ZERO |=>
    fault_alert_word[F_CHG_OC]) else $error("no charge oc alert");
  a_alert_drop: assert property (!cond[F_DSG_OC] |=>
    !fault_alert_word[F_DSG_OC]) else $error("alert stuck");
  a_zero_off: assert property (times_reg[F_CHG_OT*TIME_W +: TIME_W] ==
    TIME_ZERO |=> !fault_alert_word[F_CHG_OT])
    else $error("disabled fault alerted");
  a_latch_hold: assert property (fault_latched_word[F_DSG_OT] &&
    !clear_reg |=> fault_latched_word[F_DSG_OT])
    else $error("latch dropped");
  a_tick_gap: assert property (tick |=> !tick)
    else $error("tick too dense");

  c_latch: cover property ($rose(pf_any));
  c_fuse: cover property (fuse_hit);
  c_clear: cover property (pf_any ##1 clear_reg ##1 !pf_any);
  c_lock_err: cover property (pslverr && pready);
endmodule // psf_safety_top

// ---- bench/psf_pack_model.sv ----
// pack side model: power switches and the fuse the block can blow
`timescale 1ns/1ps
module psf_pack_model (
  input  wire logic pclk,
  input  wire logic chg_fet_on,
  input  wire logic dsg_fet_on,
  input  wire logic pchg_fet_on,
  input  wire logic safety_out,
  output logic      pack_open,
  output logic      fuse_blown
);
  // pack is cut off only when every switch is open
  assign pack_open = ~(chg_fet_on | dsg_fet_on | pchg_fet_on);

  // a blown fuse never heals, so no reset path here
  initial begin
    fuse_blown = 1'b0;
  end
  always @(posedge pclk) begin
    if (safety_out === 1'b1) begin
      fuse_blown <= 1'b1;
    end
  end
endmodule // psf_pack_model

// ---- bench/tb.sv ----
// self-checking bench for the permanent-failure safety block
`timescale 1ns/1ps
module tb;
  import psf_pkg::*;
  localparam int TK = 20;
  logic      pclk          = 1'b0;
  logic      presetn       = 1'b0;
  logic      psel          = 1'b0;
  logic      penable       = 1'b0;
  logic      pwrite        = 1'b0;
  psf_addr_t paddr         = 8'h00;
  psf_word_t pwdata        = 32'h0;
  psf_half_t meas_current  = 16'h0;
  psf_half_t meas_temp     = 16'h0100;
  logic      discharging   = 1'b0;
  psf_half_t sbs_voltage   = 16'h0;
  psf_half_t afe_status    = 16'h0;
  psf_word_t prdata;
  logic      pready;
  logic      pslverr;
  logic      chg_fet_on;
  logic      dsg_fet_on;
  logic      pchg_fet_on;
  logic      chg_alarm;
  logic      dsg_alarm;
  psf_half_t ccr;
  psf_half_t cvr;
  logic      safety_out;
  logic      fault_latched;
  logic      pack_open;
  logic      fuse_blown;
  int        miscompares   = 0;
  int        checked       = 0;
  int        cycles        = 0;
  logic [31:0] seed        = 32'd28;
  psf_word_t rd;
  logic      err;

  psf_safety_top #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_current(meas_current), .meas_temp(meas_temp),
    .discharging(discharging), .sbs_voltage(sbs_voltage),
    .afe_status(afe_status), .chg_fet_on(chg_fet_on),
    .dsg_fet_on(dsg_fet_on), .pchg_fet_on(pchg_fet_on),
    .terminate_charge_alarm(chg_alarm),
    .terminate_discharge_alarm(dsg_alarm),
    .charge_current_req(ccr), .charge_voltage_req(cvr),
    .safety_out(safety_out), .fault_latched(fault_latched));
  psf_pack_model pack (.pclk(pclk), .chg_fet_on(chg_fet_on),
    .dsg_fet_on(dsg_fet_on), .pchg_fet_on(pchg_fet_on),
    .safety_out(safety_out), .pack_open(pack_open),
    .fuse_blown(fuse_blown));

  always #2 pclk = ~pclk;

  // hang guard, far above the several hundred cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input psf_word_t seen, input psf_word_t exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step_rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endtask

  // one apb transfer; answer taken at the rising edge that sees pready
  task automatic apb(input logic is_wr, input psf_addr_t a,
                     input psf_word_t d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input psf_addr_t a, input psf_word_t d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input psf_addr_t a, input psf_word_t e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // fresh snapshot sources ride along with every change of measurement
  task automatic drive(input psf_half_t c, input psf_half_t t, input logic d);
    step_rnd();
    @(posedge pclk);
    meas_current <= c;
    meas_temp    <= t;
    discharging  <= d;
    sbs_voltage  <= seed[15:0];
    afe_status   <= seed[31:16];
  endtask

  initial begin
    int n;
    psf_half_t c;
    psf_half_t t;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check({29'h0, chg_fet_on, dsg_fet_on, pchg_fet_on}, 32'h0);
    rchk(A_TIMES, 32'h0);
    rchk(A_CHG_OC, 32'h7fff);
    rchk(A_CTRL, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    check({31'h0, err}, 32'h1);
    // final limits sit above the lower-tier thresholds
    wr(A_CHG_OC, 32'h1000);
    wr(A_DSG_OC, 32'h0800);
    wr(A_CHG_OT, 32'h0300);
    wr(A_DSG_OT, 32'h0320);
    $display("test reset done");

    // charge temp armed but discharging; charge current at its limit with time 0
    wr(A_TIMES, 32'h0001_0000);
    drive(16'h1000, 16'h0310, 1'b1);
    repeat (60) @(negedge pclk);
    rchk(A_ALERT, 32'h0);
    check({31'h0, fault_latched}, 32'h0);
    $display("test disabled done");

    // short pulse then one count below the limit: no latch
    wr(A_TIMES, 32'h0000_0002);
    drive(16'h1000, 16'h0100, 1'b0);
    rchk(A_ALERT, 32'h1);
    drive(16'h0fff, 16'h0100, 1'b0);
    repeat (3) @(negedge pclk);
    rchk(A_ALERT, 32'h0);
    repeat (60) @(negedge pclk);
    check({31'h0, fault_latched}, 32'h0);
    $display("test transient done");

    // each fault in turn; fuse enabled on the odd ones only
    for (int f = 0; f < 4; f++) begin
      c = (f == 0) ? 16'h1000 : (f == 1) ? 16'hf800 : 16'h0;
      t = (f == 2) ? 16'h0300 : (f == 3) ? 16'h0320 : 16'h0100;
      step_rnd();
      wr(A_TIMES, 32'h2 << (8 * f));
      wr(A_PF_CFG, {31'h0, f[0]} << f);
      wr(A_CHG_CUR, {16'h0, seed[15:0]});
      wr(A_CHG_VOLT, {16'h0, seed[31:16]});
      wr(A_CTRL, 32'h7);
      // request register, then the output flop one cycle later
      repeat (2) @(negedge pclk);
      check({29'h0, chg_fet_on, dsg_fet_on, pchg_fet_on}, 32'h7);
      check({ccr, cvr}, {seed[15:0], seed[31:16]});
      drive(c, t, f == 3);
      rchk(A_ALERT, 32'h1 << f);
      n = 0;
      while (fault_latched !== 1'b1 && n < 80) begin
        @(negedge pclk);
        n++;
      end
      check({31'h0, n >= 17 && n <= 45}, 32'h1);
      check({29'h0, chg_fet_on, dsg_fet_on, pchg_fet_on}, 32'h0);
      check({30'h0, chg_alarm, dsg_alarm}, 32'h3);
      check({ccr, cvr}, 32'h0);
      check({31'h0, safety_out}, {31'h0, f[0]});
      check({31'h0, pack_open}, 32'h1);
      rchk(A_LATCHED, 32'h1 << f);
      rchk(A_FUSE, f[0] ? 32'h0000_3672 : 32'h0);
      check({31'h0, fuse_blown}, {31'h0, f != 0});
      rchk(A_BSTAT, {28'h0, 1'b1, f == 3, 2'b11});
      rchk(A_SNAP0, {sbs_voltage, meas_current});
      rchk(A_SNAP1, {afe_status, meas_temp});
      wr(A_CHG_OC, 32'h0001);
      check({31'h0, err}, 32'h1);
      rchk(A_CHG_OC, 32'h1000);
      drive(16'h0, 16'h0100, 1'b0);
      repeat (30) @(negedge pclk);
      check({31'h0, fault_latched}, 32'h1);
      wr(A_CTRL, 32'h8);
      repeat (4) @(negedge pclk);
      check({31'h0, fault_latched}, 32'h0);
      rchk(A_LATCHED, 32'h0);
      $display("test fault %0d done", f);
    end
    tally_and_finish();
  end
endmodule // tb
